// ---- inc/tsbl_pkg.sv ----
package tsbl_pkg;
    // ------------------------------------------------------------
    // register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BTE = 8'h04;
    localparam logic [7:0] OFF_T0LIM = 8'h08;
    localparam logic [7:0] OFF_T1LIM = 8'h0c;
    localparam logic [7:0] OFF_SDLIM = 8'h10;
    localparam logic [7:0] OFF_C0LIM = 8'h14;
    localparam logic [7:0] OFF_STAT = 8'h18;
    localparam int ADDR_DEC_W = 8;

    // ------------------------------------------------------------
    // field layout
    // ------------------------------------------------------------
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_RUN_BIT = 1;
    localparam int CTRL_PWD_LSB = 4;
    localparam int PWD_W = 4;
    localparam int NUM_OC = 4;
    localparam int BTE_SYNC_LSB = 0;
    localparam int BTE_CLK_BIT = 4;
    localparam int BTE_W = 8;
    localparam int LIM_W = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_JUMP_BIT = 1;
    localparam int STAT_C0_LSB = 16;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [LIM_W-1:0] LIM_RST = 16'h0000;
    localparam logic [BTE_W-1:0] BTE_RST = 8'h00;
    localparam logic [PWD_W-1:0] PWD_RST = 4'h0;

    // ------------------------------------------------------------
    // step command byte: cmd in [7:4], option in [3:0]
    // ------------------------------------------------------------
    localparam logic [3:0] CMD_CTRL = 4'h1;
    localparam logic [3:0] CMD_WAIT_T0 = 4'h2;
    localparam logic [3:0] CMD_WAIT_T1 = 4'h3;
    localparam logic [3:0] CMD_JMP_C0 = 4'h4;
    localparam logic [3:0] OPT_BCAST = 4'hf;

    typedef enum logic [1:0] {
        TSBL_IDLE = 2'b00,
        TSBL_WAIT = 2'b01,
        TSBL_DELAY = 2'b11
    } tsbl_state_e;
endpackage

// ---- inc/tsbl_cnt_if.sv ----
`timescale 1ns/100ps
interface tsbl_cnt_if #(parameter int W = 16);
    logic start;
    logic [W-1:0] limit;
    logic done;
    logic [W-1:0] count;
    modport owner (output start, output limit, input done, input count);
    modport cnt (input start, input limit, output done, output count);
endinterface

// ---- hdl/tsbl_lim_cnt.sv ----
`timescale 1ns/100ps
module tsbl_lim_cnt #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst,
    tsbl_cnt_if.cnt c
);
    typedef struct packed {
        logic run;
        logic [W-1:0] cnt;
        logic done;
    } tsbl_cnt_s;

    tsbl_cnt_s st_q;
    tsbl_cnt_s st_d;

    // done is a one-cycle pulse limit+1 clocks after start
    always_comb
    begin
        st_d = st_q;
        st_d.done = 1'b0;
        if (c.start)
        begin
            st_d.run = 1'b1;
            st_d.cnt = '0;
        end
        else if (st_q.run)
        begin
            if (st_q.cnt == c.limit)
            begin
                st_d.run = 1'b0;
                st_d.done = 1'b1;
            end
            else
            begin
                st_d.cnt = st_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign c.done = st_q.done;
    assign c.count = st_q.cnt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_cnt_done_time: assert property ( // [RULE7]
        (st_q.run && !c.start && st_q.cnt == c.limit) |=> (st_q.done && !st_q.run))
        else $error("count did not end at its limit");
    a_cnt_no_early: assert property (
        c.start |=> (!st_q.done && st_q.run && st_q.cnt == '0))
        else $error("counter start not taken");
endmodule

// ---- hdl/tsbl_pulse.sv ----
`timescale 1ns/100ps
module tsbl_pulse #(
    parameter int CW = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    input wire logic [CW-1:0] width,
    output logic pulse
);
    typedef struct packed {
        logic out;
        logic [CW-1:0] cnt;
    } tsbl_pulse_s;

    tsbl_pulse_s st_q;
    tsbl_pulse_s st_d;

    // high for width+1 clocks; a new fire restarts the width
    always_comb
    begin
        st_d = st_q;
        if (fire)
        begin
            st_d.out = 1'b1; // [RULE10]
            st_d.cnt = width;
        end
        else if (st_q.cnt != '0)
        begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
        else
        begin
            st_d.out = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign pulse = st_q.out;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pulse_start: assert property ( // [RULE10]
        fire |=> (pulse && st_q.cnt == $past(width)))
        else $error("pulse did not start with its width");
    a_pulse_end: assert property ( // [RULE10]
        (pulse && st_q.cnt == '0 && !fire) |=> !pulse)
        else $error("pulse outlived its width");
endmodule

// ---- hdl/tsbl_top.sv ----
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
// Functional notes
// [RULE1]: a broadcast step sends one clock pulse to compare unit 1 only if its clock enable is set.
// [RULE2]: a broadcast step sends a sync pulse to each compare unit 1..4 whose enable bit 0..3 is set.
// [RULE3]: the broadcast enables are used only by the control step with option 1111.
// [RULE4]: while module-on and running are both 1 these registers ignore software writes.
// [RULE5]: timer 0 limit is the terminal count of timer 0, used only by the timer 0 wait step.
// [RULE6]: timer 1 limit is the terminal count of timer 1, used only by the timer 1 wait step.
// [RULE7]: every step takes the step-delay value plus one clock from start to completion; wait steps here take timer limit plus step delay plus 3 clocks.
// [RULE8]: counter 0 limit is the loop count of the counter 0 jump step.
// [RULE9]: the limit registers reset to zero and are readable and writable by software.
// [RULE10]: every trigger pulse is high for the pulse-width field plus one clock.
// [RULE11]: all enabled broadcast outputs rise in one clock, disabled ones stay low.
module tsbl_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    input wire logic STEP_VALID,
    input wire logic [7:0] STEP_CMD,
    output logic STEP_BUSY,
    output logic STEP_DONE,
    output logic JUMP_TAKEN,
    output logic [tsbl_pkg::NUM_OC-1:0] OC_SYNC,
    output logic OC_CLK
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic dph_act;
        logic dph_wr;
        logic [tsbl_pkg::ADDR_DEC_W-1:0] dph_addr;
        logic [31:0] rdata;
        logic on;
        logic run;
        logic [tsbl_pkg::PWD_W-1:0] pwd;
        logic [tsbl_pkg::BTE_W-1:0] bte;
        logic [tsbl_pkg::LIM_W-1:0] t0;
        logic [tsbl_pkg::LIM_W-1:0] t1;
        logic [tsbl_pkg::LIM_W-1:0] sd;
        logic [tsbl_pkg::LIM_W-1:0] c0;
        logic [tsbl_pkg::LIM_W-1:0] c0_cnt;
        tsbl_pkg::tsbl_state_e fsm;
        logic [3:0] cmd;
        logic busy;
        logic jump;
    } tsbl_top_s;

    tsbl_top_s st_q;
    tsbl_top_s st_d;

    logic lock;
    logic ahb_take;
    logic step_go;
    logic bcast_go;
    logic [tsbl_pkg::NUM_OC-1:0] fire_sync;
    logic fire_clk;

    tsbl_cnt_if #(.W(tsbl_pkg::LIM_W)) t0_if ();
    tsbl_cnt_if #(.W(tsbl_pkg::LIM_W)) t1_if ();
    tsbl_cnt_if #(.W(tsbl_pkg::LIM_W)) sd_if ();

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    function automatic logic [31:0] rd_mux(
        input logic [tsbl_pkg::ADDR_DEC_W-1:0] a,
        input tsbl_top_s s
    );
        logic [31:0] r;
        r = '0;
        unique case (a)
            tsbl_pkg::OFF_CTRL:
            begin
                r[tsbl_pkg::CTRL_ON_BIT] = s.on;
                r[tsbl_pkg::CTRL_RUN_BIT] = s.run;
                r[tsbl_pkg::CTRL_PWD_LSB +: tsbl_pkg::PWD_W] = s.pwd;
            end
            tsbl_pkg::OFF_BTE: r[tsbl_pkg::BTE_W-1:0] = s.bte;
            tsbl_pkg::OFF_T0LIM: r[tsbl_pkg::LIM_W-1:0] = s.t0; // [RULE9]
            tsbl_pkg::OFF_T1LIM: r[tsbl_pkg::LIM_W-1:0] = s.t1; // [RULE9]
            tsbl_pkg::OFF_SDLIM: r[tsbl_pkg::LIM_W-1:0] = s.sd; // [RULE9]
            tsbl_pkg::OFF_C0LIM: r[tsbl_pkg::LIM_W-1:0] = s.c0; // [RULE9]
            tsbl_pkg::OFF_STAT:
            begin
                r[tsbl_pkg::STAT_BUSY_BIT] = s.busy;
                r[tsbl_pkg::STAT_JUMP_BIT] = s.jump;
                r[tsbl_pkg::STAT_C0_LSB +: tsbl_pkg::LIM_W] = s.c0_cnt;
            end
            default: r = '0;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    assign lock = st_q.on & st_q.run; // [RULE4]
    assign ahb_take = HSEL & HREADY & HTRANS[1];
    assign step_go = STEP_VALID & lock & (st_q.fsm == tsbl_pkg::TSBL_IDLE);
    // broadcast enables looked at for this one command only
    assign bcast_go = step_go & (STEP_CMD[7:4] == tsbl_pkg::CMD_CTRL)
        & (STEP_CMD[3:0] == tsbl_pkg::OPT_BCAST); // [RULE3]
    // one shared strobe keeps all enabled units in step
    assign fire_sync = {tsbl_pkg::NUM_OC{bcast_go}}
        & st_q.bte[tsbl_pkg::BTE_SYNC_LSB +: tsbl_pkg::NUM_OC]; // [RULE2] [RULE11]
    assign fire_clk = bcast_go & st_q.bte[tsbl_pkg::BTE_CLK_BIT]; // [RULE1]

    assign t0_if.limit = st_q.t0; // [RULE5]
    assign t1_if.limit = st_q.t1; // [RULE6]
    assign sd_if.limit = st_q.sd; // [RULE7]

    // timers start only on their own wait step
    assign t0_if.start = step_go & (STEP_CMD[7:4] == tsbl_pkg::CMD_WAIT_T0); // [RULE5]
    assign t1_if.start = step_go & (STEP_CMD[7:4] == tsbl_pkg::CMD_WAIT_T1); // [RULE6]
    // the delay runs after the wait, or at once for every other step
    assign sd_if.start = (step_go & ~t0_if.start & ~t1_if.start)
        | ((st_q.fsm == tsbl_pkg::TSBL_WAIT)
        & (((st_q.cmd == tsbl_pkg::CMD_WAIT_T0) & t0_if.done)
        | ((st_q.cmd == tsbl_pkg::CMD_WAIT_T1) & t1_if.done))); // [RULE7]

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;

        // data phase write; control register stays writable so
        // software can always stop the sequencer
        if (st_q.dph_act && st_q.dph_wr)
        begin
            unique case (st_q.dph_addr)
                tsbl_pkg::OFF_CTRL:
                begin
                    st_d.on = HWDATA[tsbl_pkg::CTRL_ON_BIT];
                    st_d.run = HWDATA[tsbl_pkg::CTRL_RUN_BIT];
                    st_d.pwd = HWDATA[tsbl_pkg::CTRL_PWD_LSB +: tsbl_pkg::PWD_W];
                end
                tsbl_pkg::OFF_BTE:
                begin
                    if (!lock)
                        st_d.bte = HWDATA[tsbl_pkg::BTE_W-1:0]; // [RULE4]
                end
                tsbl_pkg::OFF_T0LIM:
                begin
                    if (!lock)
                        st_d.t0 = HWDATA[tsbl_pkg::LIM_W-1:0]; // [RULE4] [RULE9]
                end
                tsbl_pkg::OFF_T1LIM:
                begin
                    if (!lock)
                        st_d.t1 = HWDATA[tsbl_pkg::LIM_W-1:0]; // [RULE4] [RULE9]
                end
                tsbl_pkg::OFF_SDLIM:
                begin
                    if (!lock)
                        st_d.sd = HWDATA[tsbl_pkg::LIM_W-1:0]; // [RULE4] [RULE9]
                end
                tsbl_pkg::OFF_C0LIM:
                begin
                    if (!lock)
                        st_d.c0 = HWDATA[tsbl_pkg::LIM_W-1:0]; // [RULE4] [RULE9]
                end
                default:
                begin
                end
            endcase
        end

        // step sequencing
        unique case (st_q.fsm)
            tsbl_pkg::TSBL_IDLE:
            begin
                if (step_go)
                begin
                    st_d.cmd = STEP_CMD[7:4];
                    if (t0_if.start || t1_if.start)
                        st_d.fsm = tsbl_pkg::TSBL_WAIT;
                    else
                        st_d.fsm = tsbl_pkg::TSBL_DELAY;
                    if (STEP_CMD[7:4] == tsbl_pkg::CMD_JMP_C0)
                    begin
                        // loop count reached: fall through and rearm
                        if (st_q.c0_cnt == st_q.c0)
                        begin
                            st_d.c0_cnt = '0; // [RULE8]
                            st_d.jump = 1'b0;
                        end
                        else
                        begin
                            st_d.c0_cnt = st_q.c0_cnt + 1'b1; // [RULE8]
                            st_d.jump = 1'b1;
                        end
                    end
                end
            end
            tsbl_pkg::TSBL_WAIT:
            begin
                if (sd_if.start)
                    st_d.fsm = tsbl_pkg::TSBL_DELAY;
            end
            tsbl_pkg::TSBL_DELAY:
            begin
                if (sd_if.done)
                    st_d.fsm = tsbl_pkg::TSBL_IDLE;
            end
            default: st_d.fsm = tsbl_pkg::TSBL_IDLE;
        endcase
        st_d.busy = (st_d.fsm != tsbl_pkg::TSBL_IDLE);

        // address phase; read sees this cycle's write
        st_d.dph_act = ahb_take;
        st_d.dph_wr = HWRITE;
        st_d.dph_addr = HADDR[tsbl_pkg::ADDR_DEC_W-1:0];
        if (ahb_take && !HWRITE)
            st_d.rdata = rd_mux(HADDR[tsbl_pkg::ADDR_DEC_W-1:0], st_d);
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            st_q <= '0;
            st_q.pwd <= tsbl_pkg::PWD_RST;
            st_q.bte <= tsbl_pkg::BTE_RST;
            st_q.t0 <= tsbl_pkg::LIM_RST; // [RULE9]
            st_q.t1 <= tsbl_pkg::LIM_RST; // [RULE9]
            st_q.sd <= tsbl_pkg::LIM_RST; // [RULE9]
            st_q.c0 <= tsbl_pkg::LIM_RST; // [RULE9]
            st_q.fsm <= tsbl_pkg::TSBL_IDLE;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // counters and trigger pulses
    // ------------------------------------------------------------
    tsbl_lim_cnt #(.W(tsbl_pkg::LIM_W)) u_t0 (.clk(CLK), .rst(RST), .c(t0_if));
    tsbl_lim_cnt #(.W(tsbl_pkg::LIM_W)) u_t1 (.clk(CLK), .rst(RST), .c(t1_if));
    tsbl_lim_cnt #(.W(tsbl_pkg::LIM_W)) u_sd (.clk(CLK), .rst(RST), .c(sd_if));

    genvar gi;
    generate
        for (gi = 0; gi < tsbl_pkg::NUM_OC; gi++)
        begin : g_sync
            tsbl_pulse #(.CW(tsbl_pkg::PWD_W)) u_sync (
                .clk(CLK),
                .rst(RST),
                .fire(fire_sync[gi]),
                .width(st_q.pwd),
                .pulse(OC_SYNC[gi])
            );
        end
    endgenerate

    tsbl_pulse #(.CW(tsbl_pkg::PWD_W)) u_clk (
        .clk(CLK),
        .rst(RST),
        .fire(fire_clk),
        .width(st_q.pwd),
        .pulse(OC_CLK)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = st_q.rdata;
    assign STEP_BUSY = st_q.busy;
    assign STEP_DONE = sd_if.done;
    assign JUMP_TAKEN = st_q.jump;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_bcast_sync_set: assert property ( // [RULE2]
        bcast_go |=> ((OC_SYNC & $past(st_q.bte[3:0])) == $past(st_q.bte[3:0])))
        else $error("enabled sync pulse missing");
    a_bcast_clk_one: assert property ( // [RULE1]
        (bcast_go && st_q.bte[tsbl_pkg::BTE_CLK_BIT]) |=> OC_CLK)
        else $error("enabled clock pulse missing");
    a_fire_only_bcast: assert property ( // [RULE3]
        (|fire_sync || fire_clk) |-> bcast_go)
        else $error("trigger fired outside broadcast step");
    a_fire_masked: assert property ( // [RULE11]
        (!$past(RST) && !(|$past(OC_SYNC)) && $past(bcast_go))
        |-> (OC_SYNC == $past(st_q.bte[3:0])))
        else $error("broadcast outputs not aligned to enables");
    a_lock_holds: assert property ( // [RULE4]
        (st_q.dph_act && st_q.dph_wr && lock
        && st_q.dph_addr == tsbl_pkg::OFF_T0LIM) |=> $stable(st_q.t0))
        else $error("locked limit register written");
    a_limit_write: assert property ( // [RULE9]
        (st_q.dph_act && st_q.dph_wr && !lock
        && st_q.dph_addr == tsbl_pkg::OFF_SDLIM)
        |=> (st_q.sd == $past(HWDATA[15:0])))
        else $error("step delay write lost");
    a_jump_loop: assert property ( // [RULE8]
        (step_go && STEP_CMD[7:4] == tsbl_pkg::CMD_JMP_C0
        && st_q.c0_cnt != st_q.c0)
        |=> (JUMP_TAKEN && st_q.c0_cnt == $past(st_q.c0_cnt) + 16'h0001))
        else $error("jump loop count wrong");
    a_step_delay: assert property ( // [RULE7]
        (step_go && STEP_CMD[7:4] == tsbl_pkg::CMD_CTRL && st_q.sd == 16'h0002)
        |-> ##4 STEP_DONE)
        else $error("step delay not delay plus one");
    a_t0_wait_only: assert property ( // [RULE5]
        t0_if.start |-> (step_go && STEP_CMD[7:4] == tsbl_pkg::CMD_WAIT_T0))
        else $error("timer 0 started outside its step");
endmodule

// ---- test/tsbl_core_model.sv ----
`timescale 1ns/100ps
// ------------------------------------------------------------
// sequencer core and compare units seen from the step port
// ------------------------------------------------------------
module tsbl_core_model (
    input wire logic clk,
    input wire logic busy,
    input wire logic done,
    input wire logic [3:0] oc_sync,
    input wire logic oc_clk,
    output logic step_valid,
    output logic [7:0] step_cmd
);
    initial
    begin
        step_valid = 1'b0;
        step_cmd = 8'h00;
    end

    // request stays up until busy shows it was taken; latency and pulse
    // width are counted in edges from the first busy cycle
    task automatic do_step(input logic [7:0] cmd, output logic [4:0] pat, output int lat,
        output int wid);
        int k;
        k = 0;
        lat = 0;
        wid = 0;
        step_valid <= 1'b1;
        step_cmd <= cmd;
        do
            @(posedge clk);
        while (busy !== 1'b1 && ++k < 300);
        // a released command bus shows a changed value, never the old one
        step_valid <= 1'b0;
        step_cmd <= ~cmd;
        pat = {oc_clk, oc_sync};
        k = 0;
        while (k < 300 && (lat == 0 || {oc_clk, oc_sync} !== 5'h00))
        begin
            if ({oc_clk, oc_sync} !== 5'h00 && wid == k)
                wid++;
            if (done === 1'b1 && lat == 0)
                lat = k;
            @(posedge clk);
            k++;
        end
    endtask
endmodule

// ---- test/sequencer_broadcast_and_limits_tb.sv ----
`timescale 1ns/100ps
module sequencer_broadcast_and_limits_tb;
    logic clk, rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic step_valid, step_busy, step_done, jump_taken, oc_clk;
    logic [7:0] step_cmd;
    logic [3:0] oc_sync;
    logic [4:0] pat;
    int lat, wid, miscompares, checks_done, cycles;
    logic [7:0] lim_off [4];
    logic [4:0] bte_tab [5];
    logic [3:0] pwd_tab [5];
    logic [15:0] sd_tab [5];
    logic [15:0] cnt_exp [4];
    logic jt_exp [4];

    tsbl_top uut (
        .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
        .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
        .STEP_VALID(step_valid), .STEP_CMD(step_cmd), .STEP_BUSY(step_busy),
        .STEP_DONE(step_done), .JUMP_TAKEN(jump_taken), .OC_SYNC(oc_sync), .OC_CLK(oc_clk)
    );

    tsbl_core_model core (
        .clk(clk), .busy(step_busy), .done(step_done), .oc_sync(oc_sync),
        .oc_clk(oc_clk), .step_valid(step_valid), .step_cmd(step_cmd)
    );

    // ------------------------------------------------------------
    // clock, timeout and verdict
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // whole run needs a few hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // ------------------------------------------------------------
    // bus master: single word transfers
    // ------------------------------------------------------------
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do
            @(posedge clk);
        while (hreadyout !== 1'b1 && ++n < 100);
        htrans <= 2'b00;
        hwdata <= wd;
        do
            @(posedge clk);
        while (hreadyout !== 1'b1 && ++n < 100);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        ahb(1'b0, a, 32'h00000000, x);
        check(x, exp);
        check({hreadyout, hresp}, 32'h00000002);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h00000000;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        lim_off = '{tsbl_pkg::OFF_T0LIM, tsbl_pkg::OFF_T1LIM, tsbl_pkg::OFF_SDLIM,
            tsbl_pkg::OFF_C0LIM};
        bte_tab = '{5'h1f, 5'h05, 5'h1a, 5'h10, 5'h00};
        pwd_tab = '{4'h0, 4'h3, 4'hf, 4'h1, 4'h2};
        sd_tab = '{16'h0000, 16'h0002, 16'h0000, 16'h0007, 16'h0001};
        cnt_exp = '{16'h0001, 16'h0002, 16'h0000, 16'h0001};
        jt_exp = '{1'b1, 1'b1, 1'b0, 1'b1};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            rdc(lim_off[i], 32'h00000000);
            wr(lim_off[i], 32'hffffa5c3);
            rdc(lim_off[i], 32'h0000a5c3);
            wr(lim_off[i], 32'h00005a3c);
            rdc(lim_off[i], 32'h00005a3c);
        end
        rdc(tsbl_pkg::OFF_BTE, 32'h00000000);
        wr(8'h1c, 32'hffffffff);
        rdc(8'h1c, 32'h00000000);
        wr(tsbl_pkg::OFF_T0LIM, 32'h00000005);
        wr(tsbl_pkg::OFF_T1LIM, 32'h00000009);
        wr(tsbl_pkg::OFF_SDLIM, 32'h00000000);
        wr(tsbl_pkg::OFF_C0LIM, 32'h00000002);
        wr(tsbl_pkg::OFF_BTE, 32'h0000001f);
        // writes while on and running must leave every value alone
        wr(tsbl_pkg::OFF_CTRL, 32'h00000003);
        for (int i = 0; i < 4; i++)
            wr(lim_off[i], 32'h0000beef);
        wr(tsbl_pkg::OFF_BTE, 32'h000000e0);
        rdc(tsbl_pkg::OFF_T0LIM, 32'h00000005);
        rdc(tsbl_pkg::OFF_T1LIM, 32'h00000009);
        rdc(tsbl_pkg::OFF_SDLIM, 32'h00000000);
        rdc(tsbl_pkg::OFF_C0LIM, 32'h00000002);
        rdc(tsbl_pkg::OFF_BTE, 32'h0000001f);
        // broadcast steps over enable patterns, widths and delays
        for (int i = 0; i < 5; i++)
        begin
            wr(tsbl_pkg::OFF_CTRL, 32'h00000001);
            wr(tsbl_pkg::OFF_BTE, {27'h0, bte_tab[i]});
            wr(tsbl_pkg::OFF_SDLIM, {16'h0000, sd_tab[i]});
            wr(tsbl_pkg::OFF_CTRL, {24'h000000, pwd_tab[i], 4'h3});
            core.do_step(8'h1f, pat, lat, wid);
            check(pat[4], bte_tab[i][4]);
            check(pat[3:0], bte_tab[i][3:0]);
            check(wid, (bte_tab[i] != 5'h00) ? pwd_tab[i] + 1 : 0);
            check(lat, sd_tab[i] + 1);
        end
        wr(tsbl_pkg::OFF_CTRL, 32'h00000001);
        wr(tsbl_pkg::OFF_BTE, 32'h0000001f);
        wr(tsbl_pkg::OFF_SDLIM, 32'h00000000);
        wr(tsbl_pkg::OFF_CTRL, 32'h00000003);
        core.do_step(8'h10, pat, lat, wid);
        check(pat, 5'h00);
        check(lat, 1);
        core.do_step(8'h1e, pat, lat, wid);
        check(pat, 5'h00);
        core.do_step(8'h20, pat, lat, wid);
        check(pat, 5'h00);
        check(lat, 5 + 3);
        core.do_step(8'h30, pat, lat, wid);
        check(lat, 9 + 3);
        for (int i = 0; i < 4; i++)
        begin
            core.do_step(8'h40, pat, lat, wid);
            check(jump_taken, jt_exp[i]);
            rdc(tsbl_pkg::OFF_STAT, {cnt_exp[i], 14'h0000, jt_exp[i], 1'b0});
        end
        conclude();
    end
endmodule
